/* shared/evim_pkg.sv */
// Constants, register layout and bus carrier types of the interrupt mask.
package evim_pkg;

  // ****************************************************************
  // Bus geometry.
  // ****************************************************************
  localparam int unsigned EVIM_DATA_W = 32;
  localparam int unsigned EVIM_ADR_W  = 8;
  localparam int unsigned EVIM_SEL_W  = EVIM_DATA_W / 8;

  // ****************************************************************
  // Register indices; the byte address is four times the index.
  // ****************************************************************
  localparam logic [5:0] EVIM_MASK_IDX   = 6'h0E;
  localparam logic [5:0] EVIM_STATUS_IDX = 6'h0F;

  // ****************************************************************
  // Reset values.
  // ****************************************************************
  localparam logic [31:0] EVIM_MASK_RST   = 32'h00000000;
  localparam logic [31:0] EVIM_STATUS_RST = 32'h00000000;

  // ****************************************************************
  // Field positions shared by the mask and the status register.
  // ****************************************************************
  localparam int unsigned EVIM_RSVD0_BIT          = 0;
  localparam int unsigned EVIM_PLL_LOCK_BIT       = 1;
  localparam int unsigned EVIM_EXT_SYNC_RST_BIT   = 2;
  localparam int unsigned EVIM_AUTO_ACK_BIT       = 3;
  localparam int unsigned EVIM_TX_FRAME_BEGIN_BIT = 4;
  localparam int unsigned EVIM_TX_PREAMBLE_BIT    = 5;
  localparam int unsigned EVIM_TX_HEADER_BIT      = 6;
  localparam int unsigned EVIM_TX_FRAME_DONE_BIT  = 7;
  localparam int unsigned EVIM_RX_PREAMBLE_BIT    = 8;
  localparam int unsigned EVIM_RX_DELIMITER_BIT   = 9;
  localparam int unsigned EVIM_EDGE_DONE_BIT      = 10;

  // Bits that are reserved: not stored, read as zero, never gate.
  localparam logic [31:0] EVIM_RSVD_BITS = 32'h00000001;

  // ****************************************************************
  // Carrier types.
  // ****************************************************************
  typedef struct packed {
    logic                  cyc;
    logic                  stb;
    logic                  we;
    logic [EVIM_ADR_W-1:0] adr;
    logic [EVIM_SEL_W-1:0] sel;
    logic [EVIM_DATA_W-1:0] dat;
  } evim_wb_req_t;

  typedef struct packed {
    logic                   ack;
    logic [EVIM_DATA_W-1:0] dat;
  } evim_wb_rsp_t;

endpackage

/* design/evim_sticky_status.sv */
// Sticky event status bits, set by events and cleared by writing ones.
`timescale 1ns/1ps
module evim_sticky_status #(
  parameter int unsigned WIDTH = 32,
  parameter logic [31:0] RSVD  = 32'h00000001
) (
  // Clock and reset.
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Event inputs and clear strobe.
  input  wire logic [WIDTH-1:0] set_i,
  input  wire logic [WIDTH-1:0] clr_i,
  // Latched status.
  output logic      [WIDTH-1:0] status_o
);
  import evim_pkg::*;

  logic [WIDTH-1:0] status_r;
  logic [WIDTH-1:0] status_nxt;

  initial begin
    if (WIDTH != 32) begin
      $error("evim_sticky_status supports WIDTH 32 only.");
    end
  end

  // An event in the clearing cycle wins over the clear.
  always_comb begin
    status_nxt = ((status_r & ~clr_i) | set_i) & ~RSVD[WIDTH-1:0];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_r <= EVIM_STATUS_RST[WIDTH-1:0];
    end else begin
      status_r <= status_nxt;
    end
  end

  assign status_o = status_r;

endmodule

/* design/evim_irq_gate.sv */
// Per-bit mask gating of latched status onto one interrupt level.
`timescale 1ns/1ps
module evim_irq_gate #(
  parameter int unsigned WIDTH = 32,
  parameter logic [31:0] RSVD  = 32'h00000001
) (
  // Clock and reset.
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Mask and status, aligned bit for bit.
  input  wire logic [WIDTH-1:0] mask_i,
  input  wire logic [WIDTH-1:0] status_i,
  // Gated products and interrupt level.
  output logic      [WIDTH-1:0] pending_o,
  output logic                  irq_o
);

  logic [WIDTH-1:0] prod;
  logic             irq_r;

  initial begin
    if (WIDTH > 32) begin
      $error("evim_irq_gate supports WIDTH up to 32 only.");
    end
  end

  // Each mask bit gates only the status bit in its own position.
  for (genvar g = 0; g < WIDTH; g++) begin : g_bit
    if (RSVD[g]) begin : g_rsvd
      assign prod[g] = 1'b0;
    end else begin : g_live
      assign prod[g] = mask_i[g] & status_i[g];
    end
  end

  // Level stays high while any enabled status bit remains set.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |prod;
    end
  end

  assign pending_o = prod;
  assign irq_o     = irq_r;

endmodule

/* design/evim_top.sv */
// Event interrupt mask block with classic Wishbone register access.
//
// Summary of operation
// - Interrupt active when mask and status both set.
// - Mask bits align with status bit positions.
// - Writing mask zero removes that event's interrupt.
// - Clearing status bit also removes its interrupt.
// - Zero mask bit blocks its status bit.
// - Mask is 32-bit RW, reset zero.
// - Mask bit 0 reserved, no gating.
// - Bit 1 enables PLL lock interrupt.
// - Bit 2 enables external sync reset interrupt.
// - Bit 3 enables auto acknowledge trigger interrupt.
// - Bit 4 enables transmit frame begin interrupt.
// - Bit 5 enables transmit preamble sent interrupt.
// - Bit 6 enables transmit header done interrupt.
// - Bit 7 enables transmit frame done interrupt.
// - Bit 8 enables receive preamble found interrupt.
// - Bit 9 enables receive delimiter found interrupt.
// - Bit 10 enables edge processing done interrupt.
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
module evim_top #(
  parameter int unsigned DATA_W = 32
) (
  // Clock and reset.
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Wishbone slave request and answer.
  input  wire evim_pkg::evim_wb_req_t wb_req_i,
  output evim_pkg::evim_wb_rsp_t      wb_rsp_o,
  // Event pulses or levels from the transceiver core.
  input  wire logic [DATA_W-1:0]     events_i,
  // Interrupt request level and gated view.
  output logic                       irq_o,
  output logic [DATA_W-1:0]          pending_o
);
  import evim_pkg::*;

  // ****************************************************************
  // Elaboration checks.
  // ****************************************************************
  initial begin
    if (DATA_W != EVIM_DATA_W) begin
      $error("evim_top supports a 32-bit data bus only.");
    end
  end

  // ****************************************************************
  // Decode helpers.
  // ****************************************************************
  function automatic logic hit(input logic [EVIM_ADR_W-1:0] adr,
                               input logic [5:0]            idx);
    hit = (adr[EVIM_ADR_W-1:2] == idx);
  endfunction

  function automatic logic [DATA_W-1:0] lanes(
      input logic [EVIM_SEL_W-1:0] sel);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < EVIM_SEL_W; i++) begin
      m[i*8 +: 8] = {8{sel[i]}};
    end
    lanes = m;
  endfunction

  // ****************************************************************
  // Bus handshake state machine.
  // ****************************************************************
  typedef enum logic [1:0] {
    EVIM_IDLE = 2'b01,
    EVIM_ACK  = 2'b10
  } evim_state_t;

  evim_state_t       state_r;
  evim_state_t       state_nxt;
  logic              req;
  logic              wr_now;
  logic [DATA_W-1:0] wr_lanes;
  logic              mask_hit;
  logic              stat_hit;

  assign req      = wb_req_i.cyc & wb_req_i.stb;
  assign mask_hit = hit(wb_req_i.adr, EVIM_MASK_IDX);
  assign stat_hit = hit(wb_req_i.adr, EVIM_STATUS_IDX);
  assign wr_lanes = lanes(wb_req_i.sel);
  // The write lands on the edge at which the master sees ack high.
  assign wr_now   = (state_r == EVIM_ACK) & req & wb_req_i.we;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      EVIM_IDLE: begin
        if (req) begin
          state_nxt = EVIM_ACK;
        end
      end
      EVIM_ACK: begin
        state_nxt = EVIM_IDLE;
      end
      default: begin
        state_nxt = EVIM_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= EVIM_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************************************
  // Mask register.
  // ****************************************************************
  logic [DATA_W-1:0] mask_r;
  logic [DATA_W-1:0] mask_nxt;

  // Byte-lane write; a zero written to any bit withdraws its event.
  always_comb begin
    mask_nxt = mask_r;
    if (wr_now && mask_hit) begin
      mask_nxt = (mask_r & ~wr_lanes) | (wb_req_i.dat & wr_lanes);
    end
    mask_nxt = mask_nxt & ~EVIM_RSVD_BITS;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_r <= EVIM_MASK_RST;
    end else begin
      mask_r <= mask_nxt;
    end
  end

  // ****************************************************************
  // Status register.
  // ****************************************************************
  logic [DATA_W-1:0] status;
  logic [DATA_W-1:0] clr;

  assign clr = (wr_now && stat_hit) ? (wb_req_i.dat & wr_lanes) : '0;

  evim_sticky_status #(
    .WIDTH (DATA_W),
    .RSVD  (EVIM_RSVD_BITS)
  ) u_status (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .set_i    (events_i),
    .clr_i    (clr),
    .status_o (status)
  );

  // ****************************************************************
  // Interrupt gating.
  // ****************************************************************
  // Bits 1 to 10 each gate their own event: PLL lock, sync reset,
  // auto-ack trigger, tx begin, tx preamble, tx header, tx done,
  // rx preamble, rx delimiter and edge processing done. The host
  // should leave the auto-ack bit clear while auto-ack is off.
  evim_irq_gate #(
    .WIDTH (DATA_W),
    .RSVD  (EVIM_RSVD_BITS)
  ) u_gate (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .mask_i    (mask_r),
    .status_i  (status),
    .pending_o (pending_o),
    .irq_o     (irq_o)
  );

  // ****************************************************************
  // Read data and acknowledge.
  // ****************************************************************
  logic [DATA_W-1:0] rdat_r;

  // Read data is captured when the request is taken; unmapped reads zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_r <= '0;
    end else if (state_r == EVIM_IDLE && req && !wb_req_i.we) begin
      if (mask_hit) begin
        rdat_r <= mask_r;
      end else if (stat_hit) begin
        rdat_r <= status;
      end else begin
        rdat_r <= '0;
      end
    end
  end

  assign wb_rsp_o.ack = (state_r == EVIM_ACK);
  assign wb_rsp_o.dat = rdat_r;

endmodule

/* dv/evim_assertions.sv */
// Concurrent checks on the ports of the event interrupt mask block.
`timescale 1ns/1ps
module evim_assertions
  import evim_pkg::*;
#(
  parameter int unsigned DATA_W = 32
) (
  // Ports of the block.
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  input wire evim_pkg::evim_wb_req_t wb_req_i,
  input wire evim_pkg::evim_wb_rsp_t wb_rsp_o,
  input wire logic [DATA_W-1:0]      events_i,
  input wire logic                   irq_o,
  input wire logic [DATA_W-1:0]      pending_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_wr(logic [5:0] idx);
    wb_rsp_o.ack && wb_req_i.we && wb_req_i.adr[7:2] == idx
      && wb_req_i.sel == 4'hF;
  endsequence

  a_irq_pend: assert property (
    irq_o == (|$past(pending_o[DATA_W-1:1])))
    else $error("irq does not follow pending");
  a_rsvd_zero: assert property (pending_o[0] == 1'b0)
    else $error("reserved bit pends");
  a_ack_pulse: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (wb_req_i.cyc && wb_req_i.stb
    && !wb_rsp_o.ack |=> wb_rsp_o.ack)
    else $error("request not acked");
  a_mask_gate: assert property (s_wr(EVIM_MASK_IDX) |=>
    (pending_o & ~$past(wb_req_i.dat)) == '0)
    else $error("cleared mask bit still pends");
  a_stat_clear: assert property (s_wr(EVIM_STATUS_IDX) |=>
    (pending_o & $past(wb_req_i.dat) & ~$past(events_i)) == '0)
    else $error("cleared status bit still pends");
  a_pend_sticky: assert property (!(wb_rsp_o.ack && wb_req_i.we) |=>
    ($past(pending_o) & ~pending_o) == '0)
    else $error("pending bit dropped without write");
  a_rd_align: assert property (wb_rsp_o.ack && !wb_req_i.we
    && wb_req_i.adr[7:2] == EVIM_MASK_IDX
    |-> (pending_o & ~wb_rsp_o.dat) == '0)
    else $error("pending outside mask");
  a_rd_unmap: assert property (wb_rsp_o.ack && !wb_req_i.we
    && wb_req_i.adr[7:2] != EVIM_MASK_IDX
    && wb_req_i.adr[7:2] != EVIM_STATUS_IDX |-> wb_rsp_o.dat == '0)
    else $error("unmapped read not zero");
endmodule

/* dv/evim_host_model.sv */
// Host model that counts interrupt requests on the line.
`timescale 1ns/1ps
module evim_host_model (
  // Clock, reset and interrupt line.
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       irq_i,
  // Count of interrupt requests seen.
  output logic      [7:0] irq_cnt_o
);
  logic irq_q_r;
  always_ff @(posedge clk_i) begin
    irq_q_r <= irq_i;
    if (rst_i)
      irq_cnt_o <= 8'h00;
    else if (irq_i && !irq_q_r)
      irq_cnt_o <= irq_cnt_o + 8'h01;
  end
endmodule

/* dv/test_event_interrupt_mask.sv */
// Self-checking bench of the event interrupt mask block.
`timescale 1ns/1ps
module test_event_interrupt_mask;
  import evim_pkg::*;
  logic         clk_i  = 1'b0;
  logic         rst_i  = 1'b1;
  evim_wb_req_t req    = '0;
  evim_wb_rsp_t rsp;
  logic [31:0]  events = 32'h0;
  logic         irq;
  logic [31:0]  pend;
  logic [7:0]   hcnt;
  logic [31:0]  expq[$];
  logic [31:0]  m;
  logic [31:0]  e;
  logic [3:0]   wsel    = 4'hF;
  int           errors  = 0;
  int           checked = 0;

  always #25 clk_i = ~clk_i;

  evim_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req),
    .wb_rsp_o(rsp), .events_i(events), .irq_o(irq), .pending_o(pend));
  evim_host_model i_host (.clk_i(clk_i), .rst_i(rst_i), .irq_i(irq),
    .irq_cnt_o(hcnt));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    if (errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wb(input logic we, input logic [7:0] adr,
                    input logic [31:0] d, input logic [31:0] x);
    int n;
    if (!we)
      expq.push_back(x);
    @(posedge clk_i);
    req <= {2'b11, we, adr, wsel, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (rsp.ack !== 1'b1 && n < 20);
    if (n >= 20)
      errors++;
    req <= '0;
  endtask

  task automatic ev(input logic [31:0] v);
    @(posedge clk_i);
    events <= v;
    @(posedge clk_i);
    events <= 32'h0;
  endtask

  task automatic irq_is(input logic x);
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk({31'h0, irq}, {31'h0, x});
  endtask

  // Read results are compared with the oldest note in the queue.
  always @(posedge clk_i) begin
    if (rsp.ack === 1'b1 && req.we === 1'b0)
      chk(rsp.dat, expq.pop_front());
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    final_report();
  end

  initial begin
    void'($urandom(32'hC50A40B8));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h38, 32'h0, 32'h0);
    wb(1'b0, 8'h3C, 32'h0, 32'h0);
    wb(1'b0, 8'h00, 32'h0, 32'h0);
    wb(1'b1, 8'h38, 32'hFFFFFFFF, 32'h0);
    wb(1'b0, 8'h38, 32'h0, 32'hFFFFFFFE);
    wsel = 4'h2;
    wb(1'b1, 8'h38, 32'h0, 32'h0);
    wsel = 4'hF;
    wb(1'b0, 8'h38, 32'h0, 32'hFFFF00FE);
    ev(32'h1);
    irq_is(1'b0);
    for (int b = 1; b <= 10; b++) begin
      wb(1'b1, 8'h38, 32'h1 << b, 32'h0);
      ev(32'h1 << b);
      irq_is(1'b1);
      chk(pend, 32'h1 << b);
      wb(1'b0, 8'h3C, 32'h0, 32'h1 << b);
      wb(1'b1, 8'h38, 32'h0, 32'h0);
      irq_is(1'b0);
      wb(1'b1, 8'h38, 32'h1 << b, 32'h0);
      irq_is(1'b1);
      wb(1'b1, 8'h3C, 32'h1 << b, 32'h0);
      irq_is(1'b0);
    end
    chk({24'h0, hcnt}, 32'h00000014);
    repeat (4) begin
      m = $urandom & 32'hFFFFFFF7;
      e = $urandom;
      wb(1'b1, 8'h38, 32'h0, 32'h0);
      ev(e);
      irq_is(1'b0);
      wb(1'b1, 8'h38, m, 32'h0);
      irq_is(|(m & e & 32'hFFFFFFFE));
      chk(pend, m & e & 32'hFFFFFFFE);
      wb(1'b0, 8'h3C, 32'h0, e & 32'hFFFFFFFE);
      wb(1'b1, 8'h3C, 32'hFFFFFFFF, 32'h0);
      irq_is(1'b0);
    end
    final_report();
  end
endmodule

bind evim_top evim_assertions #(.DATA_W(DATA_W)) i_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
  .events_i(events_i), .irq_o(irq_o), .pending_o(pending_o));
